// ---- sswd_pkg.sv ----
// Package of timing constants and modes for the supply supervisor with watchdog.
`default_nettype none
package sswd_pkg;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned HOLD_INTERVAL_MS = 200;
  localparam int unsigned KICK_TIMEOUT_MS = 1600;
  localparam int unsigned KICK_MIN_PULSE_NS = 50;
  // One time base tick per microsecond.
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_TICKS = HOLD_INTERVAL_MS * 1000;
  localparam int unsigned KICK_TICKS = KICK_TIMEOUT_MS * 1000;
  // Shortest kick pulse in clock cycles, rounded down, at least one.
  localparam int unsigned KICK_MIN_CYCLES =
    (KICK_MIN_PULSE_NS / CLK_PERIOD_NS) > 0 ? (KICK_MIN_PULSE_NS / CLK_PERIOD_NS) : 1;
  // -----------------------------------------------------------------
  // Reset values
  // -----------------------------------------------------------------
  localparam logic RST_HOLD_ASSERTED = 1'b1;
  localparam logic BACKUP_AT_RESET = 1'b0;
  // -----------------------------------------------------------------
  // Supply selection
  // -----------------------------------------------------------------
  typedef enum logic {
    SSWD_SRC_MAIN,
    SSWD_SRC_BACKUP
  } sswd_src_t;
endpackage
`default_nettype wire

// ---- sswd_sync.sv ----
// Two-stage synchroniser for a group of level inputs.
`default_nettype none
module sswd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic mclk_i, // System clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] d_i, // Asynchronous levels.
  output logic [WIDTH-1:0] q_o // Synchronised levels.
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// ---- sswd_timer.sv ----
// Tick-driven up counter with restart, hold-clear and expiry flag.
`default_nettype none
module sswd_timer #(
  parameter int unsigned TERMINAL = 1000,
  parameter int unsigned WIDTH = $clog2(TERMINAL + 1)
) (
  input wire logic mclk_i, // System clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic clear_i, // Return count to zero and stop.
  input wire logic run_i, // Count when high.
  input wire logic tick_i, // Time base tick.
  output logic done_o // Count reached terminal value, one cycle.
);
  logic [WIDTH-1:0] cnt_q;
  logic hit;

  assign hit = (cnt_q == WIDTH'(TERMINAL - 1)) && tick_i && run_i && !clear_i;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (clear_i || hit) begin
      cnt_q <= '0;
    end else if (run_i && tick_i) begin
      cnt_q <= cnt_q + WIDTH'(1);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= hit;
    end
  end
endmodule
`default_nettype wire

// ---- sswd_top.sv ----
// Supply supervisor: reset hold, watchdog, power-fail warning, backup switch.
`default_nettype none
module sswd_top #(
  parameter int unsigned TICK_CYCLES = sswd_pkg::TICK_CYCLES,
  parameter int unsigned HOLD_TICKS = sswd_pkg::HOLD_TICKS,
  parameter int unsigned KICK_TICKS = sswd_pkg::KICK_TICKS
) (
  input wire logic mclk_i, // 250 MHz clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic supply_low_i, // Supply below reset threshold.
  input wire logic sense_low_i, // Fail sense input below reference.
  input wire logic backup_gt_main_i, // Backup exceeds main by 20 mV.
  input wire logic main_gt_backup_i, // Main exceeds backup by 20 mV.
  input wire logic kick_in_i, // Kick input level.
  input wire logic kick_in_open_i, // Kick input undriven.
  output logic reset_n_o, // Reset, active low.
  output logic reset_o, // Reset, active high.
  output logic fail_warn_n_o, // Power-fail warning, active low.
  output logic backed_supply_out_o // 1 selects backup source.
);
  // -----------------------------------------------------------------
  // Input synchronisation
  // -----------------------------------------------------------------
  logic [5:0] raw_in;
  logic [5:0] syn;
  logic supply_low;
  logic sense_low;
  logic backup_gt;
  logic main_gt;
  logic kick;
  logic kick_open;

  assign raw_in = {supply_low_i, sense_low_i, backup_gt_main_i, main_gt_backup_i,
                   kick_in_i, kick_in_open_i};

  sswd_sync #(
    .WIDTH(6)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(raw_in),
    .q_o(syn)
  );

  assign supply_low = syn[5];
  assign sense_low = syn[4];
  assign backup_gt = syn[3];
  assign main_gt = syn[2];
  assign kick = syn[1];
  assign kick_open = syn[0];

  // -----------------------------------------------------------------
  // Time base
  // -----------------------------------------------------------------
  localparam int unsigned TBW = $clog2(TICK_CYCLES + 1);
  logic [TBW-1:0] tb_q;
  logic tick;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_q <= '0;
    end else if (tick) begin
      tb_q <= '0;
    end else begin
      tb_q <= tb_q + TBW'(1);
    end
  end

  assign tick = (tb_q == TBW'(TICK_CYCLES - 1));

  // -----------------------------------------------------------------
  // Backup supply selection
  // -----------------------------------------------------------------
  sswd_pkg::sswd_src_t src_q;
  logic on_backup;

  // Main above threshold, else higher source.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_q <= sswd_pkg::SSWD_SRC_MAIN;
    end else if (!supply_low) begin
      src_q <= sswd_pkg::SSWD_SRC_MAIN;
    end else if (src_q == sswd_pkg::SSWD_SRC_MAIN && backup_gt) begin
      src_q <= sswd_pkg::SSWD_SRC_BACKUP;
    end else if (src_q == sswd_pkg::SSWD_SRC_BACKUP && main_gt) begin
      src_q <= sswd_pkg::SSWD_SRC_MAIN;
    end
  end

  assign on_backup = (src_q == sswd_pkg::SSWD_SRC_BACKUP);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      backed_supply_out_o <= sswd_pkg::BACKUP_AT_RESET;
    end else begin
      backed_supply_out_o <= on_backup;
    end
  end

  // -----------------------------------------------------------------
  // Power-fail warning
  // -----------------------------------------------------------------
  // Warning follows sense comparator, forced low while on backup.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fail_warn_n_o <= 1'b0;
    end else begin
      fail_warn_n_o <= !on_backup && !sense_low;
    end
  end

  // -----------------------------------------------------------------
  // Watchdog
  // -----------------------------------------------------------------
  logic kick_prev_q;
  logic kick_edge;
  logic hold_q;
  logic wd_enable;
  logic wd_clear;
  logic wd_fire;

  // The kick level is sampled every clock, so a pulse of the minimum width
  // spans about a dozen samples. No filter is applied: any change counts.
  // Every level change kicks.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kick_prev_q <= 1'b0;
    end else begin
      kick_prev_q <= kick;
    end
  end

  assign kick_edge = (kick != kick_prev_q);

  assign wd_enable = !kick_open && !on_backup;

  assign wd_clear = hold_q || kick_edge || !wd_enable;

  sswd_timer #(
    .TERMINAL(KICK_TICKS)
  ) u_wd (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clear_i(wd_clear),
    .run_i(wd_enable),
    .tick_i(tick),
    .done_o(wd_fire)
  );

  // -----------------------------------------------------------------
  // Reset hold
  // -----------------------------------------------------------------
  logic hold_restart;
  logic hold_done;

  // Supply low keeps restarting the timer.
  // Any trigger restarts the full hold.
  assign hold_restart = supply_low || wd_fire || on_backup;

  sswd_timer #(
    .TERMINAL(HOLD_TICKS)
  ) u_hold (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .clear_i(hold_restart),
    .run_i(hold_q),
    .tick_i(tick),
    .done_o(hold_done)
  );

  logic hold_d;

  // A trigger in the cycle of expiry wins, so a late event is never lost.
  always_comb begin
    hold_d = hold_q;
    if (hold_restart) begin
      hold_d = 1'b1;
    end else if (hold_done) begin
      hold_d = 1'b0;
    end
  end

  // Hold starts asserted so the processor sees a full power-up interval.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q <= sswd_pkg::RST_HOLD_ASSERTED;
    end else begin
      hold_q <= hold_d;
    end
  end

  // -----------------------------------------------------------------
  // Reset outputs
  // -----------------------------------------------------------------
  logic reset_n_q;
  logic reset_q;

  // Both pins load from the same next state, so they can never disagree.
  // Complementary output flops.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_n_q <= !sswd_pkg::RST_HOLD_ASSERTED;
      reset_q <= sswd_pkg::RST_HOLD_ASSERTED;
    end else begin
      reset_n_q <= !hold_d;
      reset_q <= hold_d;
    end
  end

  assign reset_n_o = reset_n_q;
  assign reset_o = reset_q;
endmodule
`default_nettype wire

// ---- sswd_top_props.sv ----
// Concurrent checks on the supply supervisor top ports.
`default_nettype none
module sswd_top_props #(
  parameter int unsigned TICK_CYCLES = sswd_pkg::TICK_CYCLES,
  parameter int unsigned HOLD_TICKS = sswd_pkg::HOLD_TICKS,
  parameter int unsigned KICK_TICKS = sswd_pkg::KICK_TICKS
) (
  input wire logic mclk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic supply_low_i, // Supply low.
  input wire logic sense_low_i, // Sense low.
  input wire logic backup_gt_main_i, // Backup higher.
  input wire logic main_gt_backup_i, // Main higher.
  input wire logic kick_in_i, // Kick level.
  input wire logic kick_in_open_i, // Kick undriven.
  input wire logic reset_n_o, // Reset, active low.
  input wire logic reset_o, // Reset, active high.
  input wire logic fail_warn_n_o, // Warning.
  input wire logic backed_supply_out_o // Backup selected.
);
  localparam int HMIN = HOLD_TICKS * TICK_CYCLES - TICK_CYCLES;
  localparam int KMAX = KICK_TICKS * TICK_CYCLES + 8;
  int low_q;
  int calm_q;
  int wd_q;
  logic kick_q;
  // Margins absorb the synchroniser delay and the tick granularity.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_q <= 0;
      calm_q <= 0;
      wd_q <= 0;
      kick_q <= 1'b0;
    end else begin
      kick_q <= kick_in_i;
      low_q <= reset_n_o ? 0 : low_q + 1;
      calm_q <= supply_low_i ? 0 : calm_q + 1;
      wd_q <= (!reset_n_o || kick_in_open_i || kick_in_i != kick_q) ? 0 : wd_q + 1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_inverse:
    assert property (reset_o == !reset_n_o) else $error("reset outputs not inverse");
  a_supply_holds_reset:
    assert property (supply_low_i [*5] |-> !reset_n_o) else $error("reset high on low supply");
  a_hold_full:
    assert property ($rose(reset_n_o) |-> low_q >= HMIN) else $error("reset pulse too short");
  a_hold_restart:
    assert property ($rose(reset_n_o) |-> calm_q >= HMIN) else $error("hold not restarted");
  a_warn_follows:
    assert property ((!backed_supply_out_o && $stable(sense_low_i)) [*6]
      |-> fail_warn_n_o == !sense_low_i) else $error("warning wrong");
  a_backup_warn_low:
    assert property (backed_supply_out_o [*3] |-> !fail_warn_n_o) else $error("warning high");
  a_backup_reset:
    assert property (backed_supply_out_o [*2] |-> !reset_n_o && reset_o)
      else $error("reset released on backup");
  a_kick_timeout:
    assert property (wd_q <= KMAX) else $error("watchdog did not fire");
endmodule
bind sswd_top sswd_top_props #(.TICK_CYCLES(TICK_CYCLES), .HOLD_TICKS(HOLD_TICKS),
  .KICK_TICKS(KICK_TICKS)) u_props (.mclk_i, .rst_n_i, .supply_low_i, .sense_low_i,
  .backup_gt_main_i, .main_gt_backup_i, .kick_in_i, .kick_in_open_i, .reset_n_o, .reset_o,
  .fail_warn_n_o, .backed_supply_out_o);
`default_nettype wire

// ---- sswd_cpu_model.sv ----
// Processor model that services the watchdog kick line.
`default_nettype none
module sswd_cpu_model (
  input wire logic mclk_i, // Clock.
  input wire logic reset_n_i, // Reset from the supervisor.
  input wire logic run_i, // Keep servicing the watchdog.
  input wire logic float_i, // Release the kick line.
  output logic kick_o, // Kick level.
  output logic kick_open_o // Kick line undriven.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl_q = 1'b0;
  int cnt_q = 0;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !run_i || cnt_q == 12) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
    if (reset_n_i && run_i && cnt_q == 12) begin
      lvl_q <= ~lvl_q;
    end
  end
  // Released line keeps no stale level.
  assign kick_open_o = float_i;
  assign kick_o = float_i ? ~lvl_q : lvl_q;
endmodule
`default_nettype wire

// ---- sswd_top_tb_top.sv ----
// Self-checking testbench of the supply supervisor.
`default_nettype none
module sswd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 2, HT = 20, KT = 50, HC = TC * HT, KC = TC * KT;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, supply_low_i = 1'b0, sense_low_i = 1'b0;
  logic backup_gt_main_i = 1'b0, main_gt_backup_i = 1'b1, run = 1'b1, flt = 1'b0;
  logic kick_in_i, kick_in_open_i, reset_n_o, reset_o, fail_warn_n_o, backed_supply_out_o;
  int errors = 0, cmp_count = 0, n;
  logic [15:0] rs = 16'h0041;
  always #2 mclk_i = ~mclk_i;
  sswd_top #(.TICK_CYCLES(TC), .HOLD_TICKS(HT), .KICK_TICKS(KT)) dut (.mclk_i, .rst_n_i,
    .supply_low_i, .sense_low_i, .backup_gt_main_i, .main_gt_backup_i, .kick_in_i,
    .kick_in_open_i, .reset_n_o, .reset_o, .fail_warn_n_o, .backed_supply_out_o);
  sswd_cpu_model cpu (.mclk_i, .reset_n_i(reset_n_o), .run_i(run), .float_i(flt),
    .kick_o(kick_in_i), .kick_open_o(kick_in_open_i));
  function automatic logic [15:0] nxt();
    rs ^= rs << 7;
    rs ^= rs >> 9;
    rs ^= rs << 8;
    return rs;
  endfunction
  task automatic step(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bounded wait for the reset output to reach a level.
  task automatic wt(input logic v, input int lim, output int c);
    c = 0;
    while (reset_n_o !== v && c < lim) begin
      step(1);
      c++;
    end
    if (c >= lim) begin
      $display("unexpected at %0t: reset output wait timed out", $time);
      errors++;
      summarize();
    end
  endtask
  function automatic logic in_hold(input int c);
    return c >= HC - TC && c <= HC + 8;
  endfunction
  initial begin
    step(4);
    rst_n_i = 1'b1;
    wt(1'b1, HC + 20, n);
    chk(in_hold(n), 1'b1);
    step(3 * KC);
    chk(reset_n_o, 1'b1);
    run = 1'b0;
    wt(1'b0, KC + 20, n);
    chk(n >= KC - 13 - 2 * TC, 1'b1);
    chk(reset_o, 1'b1);
    run = 1'b1;
    wt(1'b1, HC + 20, n);
    chk(in_hold(n), 1'b1);
    flt = 1'b1;
    step(3 * KC);
    chk(reset_n_o, 1'b1);
    flt = 1'b0;
    for (int i = 0; i < 4; i++) begin
      supply_low_i = 1'b1;
      step(nxt() % 30 + 5);
      chk(reset_n_o, 1'b0);
      supply_low_i = 1'b0;
      step(nxt() % (HC - 10) + 4);
      supply_low_i = 1'b1;
      step(3);
      supply_low_i = 1'b0;
      wt(1'b1, HC + 20, n);
      chk(in_hold(n), 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      sense_low_i = 1'(nxt() % 2);
      step(6);
      chk(fail_warn_n_o, !sense_low_i);
    end
    sense_low_i = 1'b0;
    backup_gt_main_i = 1'b1;
    main_gt_backup_i = 1'b0;
    step(8);
    chk(backed_supply_out_o, 1'b0);
    chk(fail_warn_n_o, 1'b1);
    supply_low_i = 1'b1;
    step(8);
    chk(backed_supply_out_o, 1'b1);
    chk(fail_warn_n_o, 1'b0);
    chk({reset_n_o, reset_o}, 2'h1);
    backup_gt_main_i = 1'b0;
    step(8);
    chk(backed_supply_out_o, 1'b1);
    main_gt_backup_i = 1'b1;
    step(8);
    chk(backed_supply_out_o, 1'b0);
    chk(fail_warn_n_o, 1'b1);
    chk(reset_n_o, 1'b0);
    supply_low_i = 1'b0;
    step(8);
    chk(backed_supply_out_o, 1'b0);
    wt(1'b1, HC + 20, n);
    summarize();
  end
endmodule
`default_nettype wire
